// ---- tb/mcl_board.sv ----
`default_nettype none

// =====================================================
// board side of the pins
module mcl_board (
	input  wire logic       clk,
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe,
	input  wire logic [7:0] drv,
	input  wire logic [7:0] drv_en,
	output var  logic [7:0] pin_in
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [7:0] churn = 8'h5A;

	// undriven pins never hold a level
	always @(posedge clk) churn <= ~churn;

	// board forces any state onto released pins
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & drv_en & drv) | (~pin_oe & ~drv_en & churn);
endmodule : mcl_board

`default_nettype wire

// ---- tb/mcl_properties.sv ----
`default_nettype none
`include "mcl_consts.svh"

// =====================================================
// cell and register port checker
module mcl_properties (
	input wire logic                  clk,
	input wire logic                  rst,
	input wire mcl_pkg::mcl_bus_req_t bus_req,
	input wire logic [31:0]           bus_rdata,
	input wire logic [63:0]           pterm,
	input wire logic [7:0]            pin_in,
	input wire logic [7:0]            pin_out,
	input wire logic [7:0]            pin_oe,
	input wire logic                  oe_n_pin,
	input wire logic [7:0]            feedback,
	input wire logic [7:0]            cell_unsupported
);
	timeunit 1ns;
	timeprecision 1ns;
	import mcl_pkg::*;

	mcl_cfg_t cfg;
	logic     sec;
	wire      wr_cfg = bus_req.wr && bus_req.addr == `MCL_ADDR_CFG && !sec;
	wire      set_sec = bus_req.wr && bus_req.addr == `MCL_ADDR_SEC && bus_req.wdata[0];
	wire      erase = bus_req.wr && bus_req.addr == `MCL_ADDR_ERASE && bus_req.wdata[0];
	wire      pre = bus_req.wr && bus_req.addr == `MCL_ADDR_PRELOAD && bus_req.wdata[0];
	wire      rd_cfg = bus_req.rd && bus_req.addr == `MCL_ADDR_CFG;
	wire      rd_st = bus_req.rd && bus_req.addr == `MCL_ADDR_STATUS;
	wire      gr = cfg.global_register;
	wire      gm = cfg.global_mode;

	// =====================================================
	// shadow of configuration and security
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg <= '0;
			sec <= 1'b0;
		end else if (erase) begin
			cfg <= '0;
			sec <= 1'b0;
		end else begin
			if (wr_cfg) cfg <= {bus_req.wdata[23:8], bus_req.wdata[1:0]};
			if (set_sec) sec <= 1'b1;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	a_cfg_hidden: assert property (rd_cfg && sec |=> bus_rdata == 32'h0)
		else $error("config readable while secure");
	a_sec_kept: assert property (rd_st |=> bus_rdata[16] == $past(sec))
		else $error("security bit state wrong");

	// =====================================================
	// per cell
	for (genvar i = 0; i < 8; i++) begin : g_cell
		wire       cm = cfg.cell_mode[i];
		wire [7:0] pt = pterm[i*8 +: 8];
		wire       xo = (|pt) ^ cfg.polarity[i];
		wire       ctr = (i == `MCL_CENTRE_A) || (i == `MCL_CENTRE_B);
		wire       rg = !gr && gm && !cm;
		wire       io = gm && cm;
		wire       co = gr && !gm && !cm;
		wire       di = gr && !gm && cm;
		wire       un = (!gr && !gm) || (gr && gm && !cm);
		sequence s_pin_held;
			$stable(pin_in[i])[*3];
		endsequence
		sequence s_oe_held;
			$stable(oe_n_pin)[*3];
		endsequence
		a_io_drive: assert property (io |-> pin_oe[i] == pt[0] && pin_out[i] == ((|pt[7:1]) ^ cfg.polarity[i]))
			else $error("comb io drive wrong");
		a_io_feed: assert property (s_pin_held ##0 io |-> feedback[i] == pin_in[i])
			else $error("comb io feedback wrong");
		a_reg_enable: assert property (s_oe_held ##0 rg |-> pin_oe[i] == !oe_n_pin)
			else $error("registered enable wrong");
		a_reg_load: assert property (rg && !pre ##1 rg |-> pin_out[i] == !$past(xo))
			else $error("registered load wrong");
		a_comb_out: assert property (co |-> pin_oe[i] && pin_out[i] == xo && !(ctr && feedback[i]))
			else $error("comb output wrong");
		a_ded_input: assert property (di |-> !pin_oe[i] && cell_unsupported[i] == ctr)
			else $error("dedicated input wrong");
		a_unsup_off: assert property (un |-> cell_unsupported[i] && !pin_oe[i])
			else $error("unsupported cell drives");
	end
endmodule : mcl_properties

bind mcl_top mcl_properties i_mcl_properties (.clk, .rst, .bus_req, .bus_rdata, .pterm, .pin_in,
	.pin_out, .pin_oe, .oe_n_pin, .feedback, .cell_unsupported);

`default_nettype wire

// ---- tb/tb.sv ----
`default_nettype none
`include "mcl_consts.svh"

module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import mcl_pkg::*;

	logic         clk = 1'b0;
	logic         rst = 1'b1;
	mcl_bus_req_t req = '0;
	logic [31:0]  rdata;
	logic [63:0]  pterm = '0;
	logic [7:0]   pin_in, pin_out, pin_oe, fb, uns;
	logic [7:0]   drv = 8'h00;
	logic [7:0]   drv_en = 8'h00;
	logic [7:0]   pat;
	logic         oe_n = 1'b1;
	logic         rd_seen = 1'b0;
	logic [31:0]  exp_q[$], msk_q[$];
	logic [31:0]  e, sig_lo, sig_hi;
	int           n_fail = 0;
	int           n_checks = 0;

	always #25 clk = ~clk;

	mcl_top i_mcl_top (.clk, .rst, .bus_req(req), .bus_rdata(rdata), .pterm, .pin_in, .pin_out,
		.pin_oe, .oe_n_pin(oe_n), .feedback(fb), .cell_unsupported(uns));
	mcl_board i_mcl_board (.clk, .pin_out, .pin_oe, .drv, .drv_en, .pin_in);

	// =====================================================
	// tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic op(input logic w, input logic r, input logic [3:0] a, input logic [31:0] d);
		req <= '{a, d, w, r};
		@(posedge clk);
	endtask : op

	task automatic rd(input logic [3:0] a, input logic [31:0] ex, input logic [31:0] mk);
		exp_q.push_back(ex);
		msk_q.push_back(mk);
		op(1'b0, 1'b1, a, 32'h0);
	endtask : rd

	task automatic pins(input logic [7:0] eo, input logic [7:0] eoe, input logic [7:0] efb,
		input logic [7:0] eun);
		req <= '0;
		@(negedge clk);
		chk({24'h0, pin_out}, {24'h0, eo});
		chk({24'h0, pin_oe}, {24'h0, eoe});
		chk({24'h0, fb}, {24'h0, efb});
		chk({24'h0, uns}, {24'h0, eun});
		@(posedge clk);
	endtask : pins

	task automatic summarize();
		$display("checks %0d failures %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : summarize

	// =====================================================
	// read data monitor
	always @(posedge clk) rd_seen <= req.rd;
	always @(negedge clk) begin : rd_check
		logic [31:0] ev;
		logic [31:0] mv;
		if (rd_seen && exp_q.size() > 0) begin
			ev = exp_q.pop_front();
			mv = msk_q.pop_front();
			chk(rdata & mv, ev & mv);
		end
	end

	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		$display("[FAIL] %0t run did not finish", $time);
		summarize();
	end

	// =====================================================
	// main sequence
	initial begin
		void'($urandom(32'hC5D9));
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		pins(8'h00, 8'h00, 8'h00, 8'hFF);
		rd(`MCL_ADDR_STATUS, 32'h0000FF00, 32'hFFFFFFFF);
		op(1'b1, 1'b0, `MCL_ADDR_CFG, 32'h00000002);
		pins(8'hFF, 8'h00, 8'hFF, 8'h00);
		// every mode code with random terms
		for (int k = 0; k < 8; k++) begin
			oe_n <= 1'($urandom);
			drv <= 8'($urandom);
			drv_en <= 8'($urandom);
			op(1'b1, 1'b0, `MCL_ADDR_CFG, {8'h0, 8'($urandom), {8{k[0]}}, 6'h0, k[1], k[2]});
			repeat (6) begin
				pterm <= {$urandom, $urandom};
				op(1'b0, 1'b0, 4'h0, 32'h0);
			end
			e = (k < 2 || k == 6) ? 32'h0000FF00 : (k == 5) ? 32'h00001800 : 32'h0;
			rd(`MCL_ADDR_STATUS, e, 32'h0000FF00);
		end
		// preload from board-driven pins
		pat = 8'($urandom);
		drv <= pat;
		drv_en <= 8'hFF;
		op(1'b1, 1'b0, `MCL_ADDR_CFG, 32'h0000FF01);
		repeat (3) op(1'b0, 1'b0, 4'h0, 32'h0);
		op(1'b1, 1'b0, `MCL_ADDR_PRELOAD, 32'h1);
		rd(`MCL_ADDR_STATUS, {24'h0, pat}, 32'h000000FF);
		// signature and security
		sig_lo = $urandom;
		sig_hi = $urandom;
		op(1'b1, 1'b0, `MCL_ADDR_SIG_LO, sig_lo);
		op(1'b1, 1'b0, `MCL_ADDR_SIG_HI, sig_hi);
		op(1'b1, 1'b0, `MCL_ADDR_SEC, 32'h1);
		op(1'b1, 1'b0, `MCL_ADDR_CFG, 32'h00000002);
		op(1'b1, 1'b0, `MCL_ADDR_SIG_LO, ~sig_lo);
		op(1'b1, 1'b0, `MCL_ADDR_SEC, 32'h0);
		rd(`MCL_ADDR_CFG, 32'h0, 32'hFFFFFFFF);
		rd(`MCL_ADDR_SIG_LO, sig_lo, 32'hFFFFFFFF);
		rd(`MCL_ADDR_SIG_HI, sig_hi, 32'hFFFFFFFF);
		rd(`MCL_ADDR_STATUS, 32'h00011800, 32'h0001FF00);
		op(1'b1, 1'b0, 4'hE, 32'hFFFFFFFF);
		rd(4'hF, 32'h0, 32'hFFFFFFFF);
		op(1'b1, 1'b0, `MCL_ADDR_ERASE, 32'h1);
		rd(`MCL_ADDR_STATUS, 32'h0000FF00, 32'h0001FF00);
		rd(`MCL_ADDR_SIG_HI, 32'h0, 32'hFFFFFFFF);
		repeat (2) op(1'b0, 1'b0, 4'h0, 32'h0);
		summarize();
	end
endmodule : tb

`default_nettype wire

// ---- verilog/mcl_consts.svh ----
`ifndef MCL_CONSTS_SVH
`define MCL_CONSTS_SVH

// =====================================================
// sizes
`define MCL_CELLS        8
`define MCL_PTERMS       8
`define MCL_ADDR_W       4
`define MCL_DATA_W       32
`define MCL_SIG_WORDS    2

// =====================================================
// register addresses (word index)
`define MCL_ADDR_CFG     4'h0
`define MCL_ADDR_SEC     4'h1
`define MCL_ADDR_ERASE   4'h2
`define MCL_ADDR_SIG_LO  4'h3
`define MCL_ADDR_SIG_HI  4'h4
`define MCL_ADDR_PRELOAD 4'h5
`define MCL_ADDR_STATUS  4'h6

// =====================================================
// field positions
`define MCL_CFG_GREG     0
`define MCL_CFG_GMODE    1
`define MCL_CFG_CMODE_LO 8
`define MCL_CFG_CMODE_HI 15
`define MCL_CFG_POL_LO   16
`define MCL_CFG_POL_HI   23
`define MCL_SEC_BIT      0
`define MCL_ERASE_BIT    0
`define MCL_PRELOAD_BIT  0
`define MCL_ST_FF_LO     0
`define MCL_ST_FF_HI     7
`define MCL_ST_UNSUP_LO  8
`define MCL_ST_UNSUP_HI  15
`define MCL_ST_SEC       16
`define MCL_OE_PT        0
`define MCL_OR7_LO       1

// =====================================================
// cells without comb-output feedback or dedicated input
`define MCL_CENTRE_A     3
`define MCL_CENTRE_B     4

// =====================================================
// reset values
`define MCL_CFG_RST      18'h00000
`define MCL_FF_RST       8'h00
`define MCL_WORD_RST     32'h00000000
`define MCL_OE_N_RST     1'h1

`endif

// ---- verilog/mcl_pkg.sv ----
`default_nettype none
`include "mcl_consts.svh"

package mcl_pkg;

	// =====================================================
	// cell operating modes
	typedef enum logic [2:0] {
		MCL_REG_OUT  = 3'b000,
		MCL_COMB_IO  = 3'b001,
		MCL_COMB_OUT = 3'b010,
		MCL_DED_IN   = 3'b011,
		MCL_UNSUP    = 3'b100
	} mcl_mode_t;

	// =====================================================
	// configuration word
	typedef struct packed {
		logic [`MCL_CELLS-1:0] polarity;
		logic [`MCL_CELLS-1:0] cell_mode;
		logic                  global_mode;
		logic                  global_register;
	} mcl_cfg_t;

	// =====================================================
	// register port request
	typedef struct packed {
		logic [`MCL_ADDR_W-1:0] addr;
		logic [`MCL_DATA_W-1:0] wdata;
		logic                   wr;
		logic                   rd;
	} mcl_bus_req_t;

endpackage : mcl_pkg

`default_nettype wire

// ---- verilog/mcl_sig_mem.sv ----
`default_nettype none
`include "mcl_consts.svh"

module mcl_sig_mem (
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire logic                   clr,
	input  wire logic                   wr_en,
	input  wire logic                   wr_addr,
	input  wire logic [`MCL_DATA_W-1:0] wr_data,
	input  wire logic                   rd_en,
	input  wire logic                   rd_addr,
	output var  logic [`MCL_DATA_W-1:0] rd_data
);
	import mcl_pkg::*;

	// =====================================================
	// storage
	logic [`MCL_DATA_W-1:0] mem [`MCL_SIG_WORDS];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mem[0] <= `MCL_WORD_RST;
			mem[1] <= `MCL_WORD_RST;
		end else if (clr) begin
			mem[0] <= `MCL_WORD_RST;
			mem[1] <= `MCL_WORD_RST;
		end else if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// =====================================================
	// registered read
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_data <= `MCL_WORD_RST;
		end else if (rd_en) begin
			rd_data <= mem[rd_addr];
		end
	end

endmodule : mcl_sig_mem

`default_nettype wire

// ---- verilog/mcl_top.sv ----
// Functional notes
// [R1] register 0, mode 1, cell mode 1: combinatorial I/O in registered device
// [R2] combinatorial I/O: seven terms to OR, eighth term enables buffer
// [R3] registered-device combinatorial I/O feeds back its own pin
// [R4] no registers: 100 comb output, 101 input, 111 comb I/O
// [R5] centre cells give no feedback in combinatorial output mode
// [R6] dedicated input not offered on the centre cells
// [R7] every cell flip-flop comes up low without external reset; here each is cleared low by rst
// [R8] registered cell pin shows inverted flip-flop, high after power-up
// [R9] combinatorial cell pin shows its logic function at once
// [R10] preload loads any state into registers from the pins
// [R11] security set blocks readback of the configuration pattern
// [R12] security cleared only by the whole-array erase; here rst also clears it
// [R13] 64-bit user signature storage
// [R14] signature readable whatever the security state
// [R15] programmer erases as part of programming, no user erase needed
// [R16] 0,1,0 selects registered output with all eight terms
// [R17] polarity bit drives an XOR ahead of the output
// [R18] flip-flop loads on rising edge, feeds back inverted, pin gated
// [R19] unlisted configurations are unsupported with buffer disabled
`default_nettype none
`include "mcl_consts.svh"

module mcl_top (
	input  wire logic                               clk,
	input  wire logic                               rst,
	input  wire mcl_pkg::mcl_bus_req_t              bus_req,
	output var  logic [`MCL_DATA_W-1:0]             bus_rdata,
	input  wire logic [`MCL_CELLS*`MCL_PTERMS-1:0]  pterm,
	input  wire logic [`MCL_CELLS-1:0]              pin_in,
	output var  logic [`MCL_CELLS-1:0]              pin_out,
	output var  logic [`MCL_CELLS-1:0]              pin_oe,
	input  wire logic                               oe_n_pin,
	output var  logic [`MCL_CELLS-1:0]              feedback,
	output var  logic [`MCL_CELLS-1:0]              cell_unsupported
);
	import mcl_pkg::*;

	// =====================================================
	// mode decode
	function automatic mcl_mode_t decode_mode(
		input logic greg,
		input logic gmode,
		input logic cmode,
		input logic centre
	);
		mcl_mode_t m;
		m = MCL_UNSUP;
		case ({greg, gmode, cmode})
			3'b010: begin
				m = MCL_REG_OUT; // [R16]
			end
			3'b011: begin
				m = MCL_COMB_IO; // [R1]
			end
			3'b100: begin
				m = MCL_COMB_OUT; // [R4]
			end
			3'b101: begin
				m = centre ? MCL_UNSUP : MCL_DED_IN; // [R4] [R6]
			end
			3'b111: begin
				m = MCL_COMB_IO; // [R4]
			end
			default: begin
				m = MCL_UNSUP; // [R19]
			end
		endcase
		return m;
	endfunction : decode_mode

	// =====================================================
	// helpers
	function automatic logic is_centre(input int idx);
		return (idx == `MCL_CENTRE_A) || (idx == `MCL_CENTRE_B);
	endfunction : is_centre

	function automatic logic addr_is(
		input logic [`MCL_ADDR_W-1:0] addr,
		input logic [`MCL_ADDR_W-1:0] want
	);
		return addr == want;
	endfunction : addr_is

	// =====================================================
	// state
	mcl_cfg_t              cfg;
	logic                  secure;
	logic [`MCL_CELLS-1:0] cell_ff;

	// =====================================================
	// synchroniser stages
	logic [`MCL_CELLS-1:0] pin_meta;
	logic [`MCL_CELLS-1:0] pin_sync;
	logic                  oe_n_meta;
	logic                  oe_n_sync;

	// =====================================================
	// read path
	logic [`MCL_DATA_W-1:0] rdata_q;
	logic                  sig_sel_q;
	logic [`MCL_DATA_W-1:0] sig_rdata;

	// =====================================================
	// pin synchronisers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_meta  <= `MCL_FF_RST;
			pin_sync  <= `MCL_FF_RST;
			oe_n_meta <= `MCL_OE_N_RST;
			oe_n_sync <= `MCL_OE_N_RST;
		end else begin
			pin_meta  <= pin_in;
			pin_sync  <= pin_meta;
			oe_n_meta <= oe_n_pin;
			oe_n_sync <= oe_n_meta;
		end
	end

	// =====================================================
	// address decode
	wire hit_cfg     = addr_is(bus_req.addr, `MCL_ADDR_CFG);
	wire hit_sec     = addr_is(bus_req.addr, `MCL_ADDR_SEC);
	wire hit_erase   = addr_is(bus_req.addr, `MCL_ADDR_ERASE);
	wire hit_sig_lo  = addr_is(bus_req.addr, `MCL_ADDR_SIG_LO);
	wire hit_sig_hi  = addr_is(bus_req.addr, `MCL_ADDR_SIG_HI);
	wire hit_preload = addr_is(bus_req.addr, `MCL_ADDR_PRELOAD);
	wire hit_status  = addr_is(bus_req.addr, `MCL_ADDR_STATUS);
	wire hit_sig     = hit_sig_lo || hit_sig_hi;

	// =====================================================
	// bus strobes
	wire do_erase    = bus_req.wr && hit_erase && bus_req.wdata[`MCL_ERASE_BIT];
	wire do_cfg_wr   = bus_req.wr && hit_cfg && !secure;
	wire do_sec_set  = bus_req.wr && hit_sec && bus_req.wdata[`MCL_SEC_BIT];
	wire do_sig_wr   = bus_req.wr && hit_sig && !secure;
	wire do_preload  = bus_req.wr && hit_preload && bus_req.wdata[`MCL_PRELOAD_BIT];
	wire do_sig_rd   = bus_req.rd && hit_sig;

	// =====================================================
	// configuration word
	wire mcl_cfg_t wr_cfg = '{
		polarity:        bus_req.wdata[`MCL_CFG_POL_HI:`MCL_CFG_POL_LO],
		cell_mode:       bus_req.wdata[`MCL_CFG_CMODE_HI:`MCL_CFG_CMODE_LO],
		global_mode:     bus_req.wdata[`MCL_CFG_GMODE],
		global_register: bus_req.wdata[`MCL_CFG_GREG]
	};

	// erase clears the whole array including security
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg <= `MCL_CFG_RST;
		end else if (do_erase) begin
			cfg <= `MCL_CFG_RST; // [R12]
		end else if (do_cfg_wr) begin
			cfg <= wr_cfg;
		end
	end

	// =====================================================
	// security bit
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			secure <= 1'h0;
		end else if (do_erase) begin
			secure <= 1'h0; // [R12]
		end else if (do_sec_set) begin
			secure <= 1'h1;
		end
	end

	// =====================================================
	// signature store
	mcl_sig_mem u_sig (
		.clk     (clk),
		.rst     (rst),
		.clr     (do_erase),
		.wr_en   (do_sig_wr), // [R13]
		.wr_addr (hit_sig_hi),
		.wr_data (bus_req.wdata),
		.rd_en   (do_sig_rd), // [R14]
		.rd_addr (hit_sig_hi),
		.rd_data (sig_rdata)
	);

	// =====================================================
	// cells
	mcl_mode_t             mode [`MCL_CELLS];
	logic [`MCL_CELLS-1:0] xor_out;
	logic [`MCL_CELLS-1:0] next_ff;

	for (genvar i = 0; i < `MCL_CELLS; i++) begin : g_cell
		// =====================================================
		// product term sums
		wire [`MCL_PTERMS-1:0] pt = pterm[i*`MCL_PTERMS +: `MCL_PTERMS];
		wire or_all = |pt;
		wire or_seven = |pt[`MCL_PTERMS-1:`MCL_OR7_LO];
		wire pt_enable = pt[`MCL_OE_PT];
		wire adj_pin = pin_sync[(i + 1) % `MCL_CELLS];

		// =====================================================
		// mode
		assign mode[i] = decode_mode(cfg.global_register, cfg.global_mode,
			cfg.cell_mode[i], is_centre(i));

		// =====================================================
		// or gate and polarity
		wire sum = (mode[i] == MCL_COMB_IO) ? or_seven : or_all; // [R2] [R16]
		assign xor_out[i] = sum ^ cfg.polarity[i]; // [R17]

		// =====================================================
		// cell register
		// preload takes the pin state, otherwise the D input
		assign next_ff[i] = do_preload ? pin_sync[i] : xor_out[i]; // [R10]

		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				cell_ff[i] <= 1'h0; // [R7]
			end else if (do_preload || mode[i] == MCL_REG_OUT) begin
				cell_ff[i] <= next_ff[i]; // [R18] [R10]
			end
		end

		// =====================================================
		// output, enable and feedback select
		wire oe_reg = ~oe_n_sync; // [R18]
		wire fb_comb_out = is_centre(i) ? 1'h0 : xor_out[i]; // [R5]

		always_comb begin
			pin_out[i]  = 1'h0;
			pin_oe[i]   = 1'h0;
			feedback[i] = 1'h0;
			case (mode[i])
				MCL_REG_OUT: begin
					pin_out[i]  = ~cell_ff[i]; // [R8]
					pin_oe[i]   = oe_reg; // [R18]
					feedback[i] = ~cell_ff[i]; // [R18]
				end
				MCL_COMB_IO: begin
					pin_out[i]  = xor_out[i]; // [R9]
					pin_oe[i]   = pt_enable; // [R2]
					feedback[i] = pin_sync[i]; // [R3]
				end
				MCL_COMB_OUT: begin
					pin_out[i]  = xor_out[i]; // [R9]
					pin_oe[i]   = 1'h1;
					feedback[i] = fb_comb_out; // [R5]
				end
				MCL_DED_IN: begin
					feedback[i] = adj_pin;
				end
				MCL_UNSUP: begin
					pin_oe[i]   = 1'h0; // [R19]
				end
				default: begin
					pin_oe[i]   = 1'h0;
				end
			endcase
		end

		// =====================================================
		// unsupported flag
		assign cell_unsupported[i] = mode[i] == MCL_UNSUP; // [R19]
	end

	// =====================================================
	// read data
	wire [`MCL_DATA_W-1:0] cfg_word = {
		{(`MCL_DATA_W-`MCL_CFG_POL_HI-1){1'b0}},
		cfg.polarity,
		cfg.cell_mode,
		{(`MCL_CFG_CMODE_LO-`MCL_CFG_GMODE-1){1'b0}},
		cfg.global_mode,
		cfg.global_register
	};
	wire [`MCL_DATA_W-1:0] status_word = {
		{(`MCL_DATA_W-`MCL_ST_SEC-1){1'b0}},
		secure,
		cell_unsupported,
		cell_ff
	};
	// =====================================================
	// read select
	wire [`MCL_DATA_W-1:0] sec_word = {{(`MCL_DATA_W-1){1'b0}}, secure};
	wire [`MCL_DATA_W-1:0] cfg_read = secure ? `MCL_WORD_RST : cfg_word; // [R11]
	wire [`MCL_DATA_W-1:0] next_rdata =
		!bus_req.rd ? `MCL_WORD_RST :
		hit_cfg     ? cfg_read :
		hit_sec     ? sec_word :
		hit_status  ? status_word :
		`MCL_WORD_RST;

	// =====================================================
	// read registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata_q   <= `MCL_WORD_RST;
			sig_sel_q <= 1'h0;
		end else begin
			rdata_q   <= next_rdata;
			sig_sel_q <= do_sig_rd;
		end
	end

	assign bus_rdata = sig_sel_q ? sig_rdata : rdata_q; // [R14]

endmodule : mcl_top

`default_nettype wire
